// file: include/mapt_defines.svh
/*
 * constants for the multiturn absolute position tracker.
 * assumes inclusion by bare name from any design file.
 */
`ifndef MAPT_DEFINES_SVH
`define MAPT_DEFINES_SVH

`define MAPT_REG_MODE_OFS 16'h2015
`define MAPT_OBJ_POS_OFS 16'h6064
`define MAPT_MODE_RST 16'h0000
`define MAPT_MODE_INCR 16'h0000
`define MAPT_MODE_LIN 16'h0001
`define MAPT_MODE_ROT 16'h0002
`define MAPT_MODE_SGL 16'h0003
`define MAPT_MODE_CLR_ALM 16'h0005
`define MAPT_MODE_CLR_POS 16'h0009
`define MAPT_CLK_HZ 40000000
`define MAPT_CMD_TMO_MS 3000
`define MAPT_ST17_MAX 23'h01ffff
`define MAPT_ST23_MAX 23'h7fffff

`endif

// file: include/mapt_pkg.sv
/*
 * types for the multiturn absolute position tracker.
 * assumes mapt_defines.svh is compiled alongside.
 */
package mapt_pkg;
    typedef enum logic [1:0] {
        MAPT_CMD_IDLE,
        MAPT_CMD_BUSY,
        MAPT_CMD_FAIL
    } mapt_cmd_st_t;
    typedef logic signed [15:0] mapt_rev_t;
    typedef logic [22:0] mapt_st_t;
endpackage

// file: logic/mapt_rev_counter.sv
/*
 * signed revolution counter with mode-dependent wrap.
 * assumes one-cycle step pulses from the tracker on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mapt_defines.svh"

module mapt_rev_counter
    import mapt_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clear_i,
    input wire logic step_cw_i,
    input wire logic step_ccw_i,
    input wire logic rotary_i,
    input wire logic [15:0] upper_i,
    output mapt_rev_t rev_o
);

    // -------------------------------------------------------------
    // counter
    // -------------------------------------------------------------
    mapt_rev_t rev_q;
    assign rev_o = rev_q;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || clear_i) begin
            rev_q <= '0;
        end else if (rotary_i) begin
            // stays within zero and upper plus one
            if (step_ccw_i) begin
                if ($unsigned(rev_q) >= {1'b0, upper_i} + 17'h00001) begin
                    rev_q <= '0;
                end else begin
                    rev_q <= rev_q + 16'sh0001;
                end
            end else if (step_cw_i) begin
                if (rev_q == 16'sh0000) begin
                    rev_q <= mapt_rev_t'(upper_i + 16'h0001);
                end else begin
                    rev_q <= rev_q - 16'sh0001;
                end
            end
        end else if (step_ccw_i) begin
            rev_q <= rev_q + 16'sh0001;
        end else if (step_cw_i) begin
            rev_q <= rev_q - 16'sh0001;
        end
    end

endmodule
`default_nettype wire

// file: logic/mapt_tracker.sv
/*
 * multiturn absolute position tracker: mode register, commands,
 * alarm, revolution tracking and absolute position object.
 * assumes encoder data and battery status are synchronous inputs
 * from encoder interface logic on the same clock.
 */
// Function
// - mode 0: incremental, position not retained
// - mode 1: multiturn linear retention
// - mode 2: rotary, multiturn limited to upper+1
// - mode 3: single turn, overrun flags overflow
// - write 5 clears alarm, then multiturn
// - write 9 clears position, alarm, then multiturn
// - first multiturn selection raises data alarm
// - alarm clears only homed and battery good
// - clockwise decrements, counter-clockwise increments
// - 16-bit two's complement counter wraps
// - single turn spans encoder resolution
// - low 16 bits of absolute position readable at object 6064h
// - rotary value within zero and upper+1
// - multiturn data cleared by reset
// - position clear zeroes turns, keeps absolute
`timescale 1ns/1ps
`default_nettype none
`include "mapt_defines.svh"

module mapt_tracker
    import mapt_pkg::*;
#(
    parameter int unsigned CMD_TMO_CYC =
        (`MAPT_CLK_HZ / 1000) * `MAPT_CMD_TMO_MS
)
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] rotary_turn_upper_limit_i,
    input wire logic res23_i,
    input wire logic [22:0] st_pos_i,
    input wire logic st_valid_i,
    input wire logic battery_ok_i,
    input wire logic homed_i,
    input wire logic first_install_i,
    output logic [15:0] rdata_o,
    output logic [31:0] abs_pos_o,
    output logic multiturn_data_alarm_o,
    output logic st_overflow_o,
    output logic cmd_fail_o
);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic is_mt(input logic [15:0] m);
        is_mt = (m == `MAPT_MODE_LIN) || (m == `MAPT_MODE_ROT);
    endfunction

    function automatic logic [22:0] st_max(input logic r23);
        st_max = r23 ? `MAPT_ST23_MAX : `MAPT_ST17_MAX;
    endfunction

    // -------------------------------------------------------------
    // mode register and command sequencing
    // -------------------------------------------------------------
    logic [15:0] mode_q;
    mapt_cmd_st_t cmd_st_q;
    logic [31:0] tmo_cnt_q;
    logic clr_pos_q;
    logic alarm_q;
    logic mode_wr;
    assign mode_wr = wr_en_i && (addr_i == `MAPT_REG_MODE_OFS);

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            mode_q <= `MAPT_MODE_RST;
            cmd_st_q <= MAPT_CMD_IDLE;
            tmo_cnt_q <= '0;
            clr_pos_q <= 1'b0;
        end else begin
            clr_pos_q <= 1'b0;
            if (mode_wr) begin
                mode_q <= wdata_i;
                tmo_cnt_q <= '0;
                if (wdata_i == `MAPT_MODE_CLR_ALM ||
                        wdata_i == `MAPT_MODE_CLR_POS) begin
                    cmd_st_q <= MAPT_CMD_BUSY;
                    clr_pos_q <= (wdata_i == `MAPT_MODE_CLR_POS);
                end else begin
                    cmd_st_q <= MAPT_CMD_IDLE;
                end
            end else begin
                unique case (cmd_st_q)
                    MAPT_CMD_IDLE: begin
                        tmo_cnt_q <= '0;
                    end
                    MAPT_CMD_BUSY: begin
                        if (!alarm_q) begin
                            mode_q <= `MAPT_MODE_LIN;
                            cmd_st_q <= MAPT_CMD_IDLE;
                        end else if (tmo_cnt_q >= CMD_TMO_CYC - 1) begin
                            cmd_st_q <= MAPT_CMD_FAIL;
                        end else begin
                            tmo_cnt_q <= tmo_cnt_q + 32'h00000001;
                        end
                    end
                    MAPT_CMD_FAIL: begin
                        tmo_cnt_q <= '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cmd_fail_o <= 1'b0;
        end else begin
            cmd_fail_o <= (cmd_st_q == MAPT_CMD_FAIL);
        end
    end

    // -------------------------------------------------------------
    // multiturn data alarm
    // -------------------------------------------------------------
    logic mt_sel_q;
    logic clr_ok;
    assign clr_ok = homed_i && battery_ok_i;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            mt_sel_q <= 1'b0;
        end else begin
            mt_sel_q <= is_mt(mode_q);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            alarm_q <= 1'b0;
        end else if (!battery_ok_i ||
                (is_mt(mode_q) && !mt_sel_q && first_install_i)) begin
            alarm_q <= 1'b1;
        end else if (cmd_st_q == MAPT_CMD_BUSY && clr_ok) begin
            alarm_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            multiturn_data_alarm_o <= 1'b0;
        end else begin
            multiturn_data_alarm_o <= alarm_q;
        end
    end

    // -------------------------------------------------------------
    // single turn tracking and direction detection
    // -------------------------------------------------------------
    mapt_st_t st_q;
    logic st_seen_q;
    logic step_cw;
    logic step_ccw;
    logic [22:0] half;
    logic [22:0] res_max;
    assign res_max = st_max(res23_i);
    assign half = {1'b0, res_max[22:1]};
    // wrap through zero inferred from a jump of more than half a turn
    assign step_ccw = st_valid_i && st_seen_q && (st_q > half) &&
        (st_pos_i < half) && (st_q - st_pos_i > half);
    assign step_cw = st_valid_i && st_seen_q && (st_q < half) &&
        (st_pos_i > half) && (st_pos_i - st_q > half);

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st_q <= '0;
            st_seen_q <= 1'b0;
        end else if (st_valid_i) begin
            st_q <= st_pos_i & st_max(res23_i);
            st_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st_overflow_o <= 1'b0;
        end else if (mode_q == `MAPT_MODE_SGL &&
                (step_cw || step_ccw)) begin
            // overrun in the write cycle is kept: set wins
            st_overflow_o <= 1'b1;
        end else if (mode_wr) begin
            st_overflow_o <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // revolution counter
    // -------------------------------------------------------------
    mapt_rev_t rev;
    logic rev_clr;
    // single-turn mode holds the counter at zero, as does a position clear;
    // incremental and multiturn modes keep counting until reset
    assign rev_clr = clr_pos_q || (mode_q == `MAPT_MODE_SGL);

    mapt_rev_counter u_rev (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clear_i(rev_clr),
        .step_cw_i(step_cw),
        .step_ccw_i(step_ccw),
        .rotary_i(mode_q == `MAPT_MODE_ROT),
        .upper_i(rotary_turn_upper_limit_i),
        .rev_o(rev)
    );

    // -------------------------------------------------------------
    // absolute position and object read
    // -------------------------------------------------------------
    logic [31:0] abs_next;
    logic [31:0] abs_ofs_q;
    always_comb begin
        abs_next = res23_i ? ({{16{rev[15]}}, rev} << 23)
                           : ({{16{rev[15]}}, rev} << 17);
        abs_next = abs_next + {9'h000, st_q} + abs_ofs_q;
    end

    // clearing turns keeps reported position: store prior turn term
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            abs_ofs_q <= '0;
        end else if (clr_pos_q) begin
            abs_ofs_q <= abs_next - {9'h000, st_q};
        end else if (mode_q == `MAPT_MODE_INCR ||
                mode_q == `MAPT_MODE_SGL) begin
            abs_ofs_q <= '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            abs_pos_o <= '0;
        end else begin
            abs_pos_o <= abs_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
        end else if (rd_en_i && addr_i == `MAPT_REG_MODE_OFS) begin
            rdata_o <= mode_q;
        end else if (rd_en_i && addr_i == `MAPT_OBJ_POS_OFS) begin
            rdata_o <= abs_next[15:0];
        end else if (rd_en_i) begin
            rdata_o <= '0;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    property p_cmd5_done;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (cmd_st_q == MAPT_CMD_BUSY && !alarm_q && !mode_wr)
            |=> mode_q == `MAPT_MODE_LIN;
    endproperty
    a_cmd5_done: assert property (p_cmd5_done)
        else $error("command did not switch to multiturn");

    property p_clrpos;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        clr_pos_q |=> rev == 16'sh0000;
    endproperty
    a_clrpos: assert property (p_clrpos)
        else $error("position clear left turns");

    property p_keep_abs;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (clr_pos_q && !st_valid_i) |=> abs_next == $past(abs_next);
    endproperty
    a_keep_abs: assert property (p_keep_abs)
        else $error("position clear moved absolute");

    property p_alarm_clear;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        ($past(alarm_q) && !alarm_q) |-> $past(clr_ok);
    endproperty
    a_alarm_clear: assert property (p_alarm_clear)
        else $error("alarm cleared without homing");

    property p_first;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (is_mt(mode_q) && !mt_sel_q && first_install_i) |=> alarm_q;
    endproperty
    a_first: assert property (p_first)
        else $error("first install raised no alarm");

    property p_ccw;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (step_ccw && !rev_clr && mode_q == `MAPT_MODE_LIN)
            |=> rev == $past(rev) + 16'sh0001;
    endproperty
    a_ccw: assert property (p_ccw)
        else $error("ccw step did not increment");

    property p_rot;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (mode_q == `MAPT_MODE_ROT && $stable(mode_q) && !rev[15] &&
            $unsigned(rev) <= {1'b0, rotary_turn_upper_limit_i} + 17'h1)
            |=> !rev[15];
    endproperty
    a_rot: assert property (p_rot)
        else $error("rotary turns went negative");

    property p_sgl;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (mode_q == `MAPT_MODE_SGL && step_cw && !mode_wr) |=> st_overflow_o;
    endproperty
    a_sgl: assert property (p_sgl)
        else $error("single turn overrun not flagged");

endmodule
`default_nettype wire

// file: tb/mapt_master_model.sv
/*
 * fieldbus master model: object writes and reads.
 * assumes the tracker samples strobes on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mapt_defines.svh"

module mapt_master_model (
    input wire logic sys_clk_i,
    input wire logic [15:0] rdata_i,
    output logic wr_en_o,
    output logic rd_en_o,
    output logic [15:0] addr_o,
    output logic [15:0] wdata_o
);
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
    end

    // caller holds the axis disabled around a write of 9
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(negedge sys_clk_i);
        wr_en_o = 1'b1;
        addr_o = a;
        wdata_o = v;
        @(negedge sys_clk_i);
        wr_en_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~v;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(negedge sys_clk_i);
        rd_en_o = 1'b1;
        addr_o = a;
        @(negedge sys_clk_i);
        rd_en_o = 1'b0;
        addr_o = ~a;
        @(negedge sys_clk_i);
        v = rdata_i;
    endtask

    // position object read twice while stopped, ok when equal
    task automatic rd_pos(output logic [15:0] v, output logic ok);
        logic [15:0] first;
        rd(`MAPT_OBJ_POS_OFS, first);
        rd(`MAPT_OBJ_POS_OFS, v);
        ok = (first === v);
    endtask
endmodule
`default_nettype wire

// file: tb/multiturn_absolute_position_tracker_test.sv
/*
 * bench for the tracker: table of samples, then hand tests.
 * assumes design files and the master model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mapt_defines.svh"

module multiturn_absolute_position_tracker_test;
    localparam int TMO = 20;
    typedef struct packed {
        logic res;
        logic [1:0] mode;
        logic [22:0] st;
        logic [31:0] exp;
    } mapt_row_t;
    logic clk = 1'b0, rstn = 1'b0, wr_en, rd_en, res23 = 1'b0;
    logic st_valid = 1'b0, bat_ok = 1'b1, homed = 1'b0, first_inst = 1'b0;
    logic [15:0] addr, wdata, rdata, upper = 16'h0002;
    logic [22:0] st_pos = 23'h000000;
    logic [31:0] abs_pos;
    logic alarm, st_ovf, cmd_fail;
    int num_errors = 0;
    int num_checks = 0;
    mapt_row_t rows [14];

    always #12.5 clk = ~clk;

    mapt_tracker #(.CMD_TMO_CYC(TMO)) mapt_tracker_i (
        .sys_clk_i(clk), .rstn_i(rstn), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .addr_i(addr), .wdata_i(wdata), .rotary_turn_upper_limit_i(upper),
        .res23_i(res23), .st_pos_i(st_pos), .st_valid_i(st_valid),
        .battery_ok_i(bat_ok), .homed_i(homed),
        .first_install_i(first_inst), .rdata_o(rdata),
        .abs_pos_o(abs_pos), .multiturn_data_alarm_o(alarm),
        .st_overflow_o(st_ovf), .cmd_fail_o(cmd_fail));
    mapt_master_model mapt_master_model_i (
        .sys_clk_i(clk), .rdata_i(rdata), .wr_en_o(wr_en),
        .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic smp(input logic [22:0] v);
        @(negedge clk);
        st_pos = v;
        st_valid = 1'b1;
        @(negedge clk);
        st_valid = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic rd_mode(input logic [15:0] m);
        logic [15:0] v;
        mapt_master_model_i.rd(`MAPT_REG_MODE_OFS, v);
        check({16'h0000, v}, {16'h0000, m});
    endtask

    task automatic set_mode(input logic [15:0] m);
        mapt_master_model_i.wr(`MAPT_REG_MODE_OFS, m);
        rd_mode(m);
    endtask

    // w=0 watches the alarm, w=1 the command failure flag
    task automatic wait_for(input int w, input logic v);
        int n;
        n = 0;
        while ((w == 1 ? cmd_fail : alarm) !== v && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, ~v, v);
            finish_test();
        end else begin
            num_checks++;
        end
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        logic [15:0] d;
        logic ok;
        logic [1:0] cur;
        rows = '{
            '{1'b0, 2'h0, 23'h000100, 32'h00000100},
            '{1'b0, 2'h0, 23'h01ff00, 32'hffffff00},
            '{1'b0, 2'h0, 23'h000100, 32'h00000100},
            '{1'b0, 2'h1, 23'h01ff00, 32'hffffff00},
            '{1'b0, 2'h1, 23'h000100, 32'h00000100},
            '{1'b0, 2'h1, 23'h010000, 32'h00010000},
            '{1'b0, 2'h1, 23'h01ff00, 32'h0001ff00},
            '{1'b0, 2'h1, 23'h000100, 32'h00020100},
            '{1'b0, 2'h0, 23'h01ff00, 32'h0001ff00},
            '{1'b0, 2'h2, 23'h00fff0, 32'h0000fff0},
            '{1'b0, 2'h2, 23'h01fff0, 32'h0007fff0},
            '{1'b0, 2'h2, 23'h000100, 32'h00000100},
            '{1'b1, 2'h1, 23'h7fffff, 32'hffffffff},
            '{1'b1, 2'h1, 23'h000100, 32'h00000100}};
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        check({abs_pos[31:3], alarm, st_ovf, cmd_fail}, 32'h0);
        rd_mode(`MAPT_MODE_RST);
        mapt_master_model_i.rd(16'h1234, d);
        check({16'h0000, d}, 32'h0);
        $display("reset test done");
        cur = 2'h0;
        foreach (rows[i]) begin
            res23 = rows[i].res;
            if (rows[i].mode !== cur) begin
                cur = rows[i].mode;
                set_mode({14'h0000, cur});
            end
            smp(rows[i].st);
            check(abs_pos, rows[i].exp);
            mapt_master_model_i.rd_pos(d, ok);
            check({16'h0000, d}, {16'h0000, rows[i].exp[15:0]});
            check({31'h0, ok}, 32'h1);
            $display("row %0d done", i);
        end
        res23 = 1'b0;
        set_mode(`MAPT_MODE_SGL);
        smp(23'h01ff00);
        smp(23'h000100);
        check({31'h0, st_ovf}, 32'h1);
        check(abs_pos, 32'h100);
        set_mode(`MAPT_MODE_LIN);
        check({31'h0, st_ovf}, 32'h0);
        $display("overflow test done");
        first_inst = 1'b1;
        // leave multiturn so that reselection counts as first
        set_mode(`MAPT_MODE_INCR);
        set_mode(`MAPT_MODE_LIN);
        wait_for(0, 1'b1);
        first_inst = 1'b0;
        mapt_master_model_i.wr(`MAPT_REG_MODE_OFS, `MAPT_MODE_CLR_ALM);
        wait_for(1, 1'b1);
        check({31'h0, alarm}, 32'h1);
        rd_mode(`MAPT_MODE_CLR_ALM);
        homed = 1'b1;
        mapt_master_model_i.wr(`MAPT_REG_MODE_OFS, `MAPT_MODE_CLR_ALM);
        wait_for(0, 1'b0);
        rd_mode(`MAPT_MODE_LIN);
        $display("alarm clear test done");
        set_mode(`MAPT_MODE_INCR);
        smp(23'h01ff00);
        check(abs_pos, 32'hffffff00);
        set_mode(`MAPT_MODE_LIN);
        smp(23'h010000);
        check(abs_pos, 32'hffff0000);
        bat_ok = 1'b0;
        wait_for(0, 1'b1);
        bat_ok = 1'b1;
        repeat (5) @(negedge clk);
        check({31'h0, alarm}, 32'h1);
        mapt_master_model_i.wr(`MAPT_REG_MODE_OFS, `MAPT_MODE_CLR_POS);
        wait_for(0, 1'b0);
        check(abs_pos, 32'hffff0000);
        rd_mode(`MAPT_MODE_LIN);
        smp(23'h01ff00);
        check(abs_pos, 32'hffffff00);
        $display("position clear test done");
        finish_test();
    end
endmodule
`default_nettype wire
